// file: logic/pic_pkg.sv
// Purpose: Shared constants for the prioritized interrupt controller
// Assumes: 32-bit AXI4-Lite register access, byte registers in the low lane
// Notes: Register offsets are indices; byte address is four times the index
package pic_pkg;

  // Source numbering follows priority, 0 is the system reset slot
  localparam int PIC_NSRC = 26;
  localparam int PIC_PW = 5;
  localparam int PIC_NREG = 3;
  localparam int PIC_NPIN = 5;
  localparam int PIC_AW = 12;

  // Register indices, byte address = index * 4
  localparam logic [7:0] PIC_IDX_POSTED_A = 8'hda;
  localparam logic [7:0] PIC_IDX_POSTED_B = 8'hdb;
  localparam logic [7:0] PIC_IDX_POSTED_C = 8'hdc;
  localparam logic [7:0] PIC_IDX_ENABLE_3 = 8'hde;
  localparam logic [7:0] PIC_IDX_ENABLE_2 = 8'hdf;
  localparam logic [7:0] PIC_IDX_ENABLE_0 = 8'he0;
  localparam logic [7:0] PIC_IDX_ENABLE_1 = 8'he1;

  // Register bit -> source priority, 0 marks a reserved bit
  localparam logic [PIC_PW-1:0] PIC_MAP [0:PIC_NREG-1][0:7] = '{
    '{5'd1, 5'd0, 5'd3, 5'd4, 5'd5, 5'd7, 5'd25, 5'd6},
    '{5'd0, 5'd0, 5'd0, 5'd0, 5'd0, 5'd13, 5'd14, 5'd0},
    '{5'd0, 5'd17, 5'd18, 5'd0, 5'd20, 5'd0, 5'd0, 5'd0}
  };

  // Edge-triggered pin sources: port 0, port 1, input one, input two, port 2
  localparam logic [PIC_PW-1:0] PIC_PIN_PRIO [0:PIC_NPIN-1] = '{
    5'd5, 5'd6, 5'd7, 5'd18, 5'd20
  };

  // Field positions
  localparam int PIC_SOFT_POST_BIT = 7;
  localparam int PIC_FLAG_IRQ_EN_BIT = 0;
  localparam int PIC_VEC_SHIFT = 2;
  localparam logic [7:0] PIC_BYTE_RESET = 8'h00;
  localparam logic [7:0] PIC_PC_UPPER_ON_VECTOR = 8'h00;

  // Dispatch timing in CPU cycles
  localparam int PIC_DISPATCH_CYCLES = 13;
  localparam logic [3:0] PIC_STEP_PUSH_HI = 4'h0;
  localparam logic [3:0] PIC_STEP_PUSH_LO = 4'h1;
  localparam logic [3:0] PIC_STEP_PUSH_FL = 4'h2;
  localparam logic [3:0] PIC_STEP_CLR_FL = 4'h3;
  localparam logic [3:0] PIC_STEP_LAST = 4'(PIC_DISPATCH_CYCLES - 1);

  // AXI responses
  localparam logic [1:0] PIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PIC_RESP_SLVERR = 2'h2;

  // Register selection codes
  typedef enum logic [2:0] {
    PIC_SEL_NONE, PIC_SEL_POST_A, PIC_SEL_POST_B, PIC_SEL_POST_C,
    PIC_SEL_EN_0, PIC_SEL_EN_1, PIC_SEL_EN_2, PIC_SEL_EN_3
  } pic_sel_t;

  typedef enum logic {PIC_IDLE, PIC_DISPATCH} pic_state_t;

endpackage : pic_pkg

// file: logic/pic_controller.sv
// Purpose: Prioritized interrupt controller with CPU dispatch sequencing
// Assumes: Peripheral event inputs are one-cycle pulses on aclk
// Notes: Pin sources pass a three-stage synchroniser and are edge detected
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - A source's trigger condition sets its posted flag.
// - Posted flag holds until acceptance or a software clear.
// - Pending means posted and mask-enabled together.
// - Masking neither erases nor blocks posting; it only hides pending.
// - Lowest-numbered pending source wins; accepted only with global enable.
// - Activation by event, by mask write, or by enable rising.
// - Current instruction finishes before dispatch starts.
// - Dispatch takes exactly 13 cycles as an automatic call.
// - Push upper PC byte, lower PC byte, then flags.
// - After pushes the flag register clears, dropping global enable.
// - Upper PC byte zeroed, lower byte loaded with the vector.
// - Return restores PC and flags, re-enabling interrupts.
// - After return, pending interrupts dispatch before the next instruction.
// - Setting global enable inside a handler allows nesting.
// - Reading a clear register shows posted flags as ones.
// - Soft post off: writing 0 clears, writing 1 does nothing.
// - Soft post on: zeros ignored, each 1 posts that source.
// - Port interrupts post on an edge, not on a level.
// - First register bits: port1, sleep, ext1, port0, rx, tx, reserved, power.
// - Second register: bit 6 interval timer, bit 5 1 ms timer.
// - Third register: bit 4 port 2, bit 2 ext2, bit 1 wrap.
// - Each mask bit gates only its own source.
// - Vector equals four times the priority number.
module pic_controller
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [pic_pkg::PIC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pic_pkg::PIC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event sources
  input wire logic [pic_pkg::PIC_NSRC-1:0] periph_event,
  input wire logic [pic_pkg::PIC_NPIN-1:0] pin_irq,
  // CPU core side
  input wire logic instr_end,
  input wire logic [15:0] cpu_program_counter,
  input wire logic flag_write,
  input wire logic [7:0] flag_wdata,
  input wire logic return_from_service,
  input wire logic [7:0] restored_flags,
  output logic [7:0] cpu_flags,
  output logic irq_request,
  output logic dispatch_busy,
  output logic stack_push,
  output logic [7:0] stack_data,
  output logic pc_load,
  output logic [15:0] pc_value
);
  import pic_pkg::*;

  // Map a byte address to a register
  function automatic pic_sel_t decode_addr(input logic [PIC_AW-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    // Upper address bits must be zero, otherwise high aliases would hit
    if (addr[1:0] != 2'h0) decode_addr = PIC_SEL_NONE;
    else if (addr[PIC_AW-1:10] != '0) decode_addr = PIC_SEL_NONE;
    else if (idx == PIC_IDX_POSTED_A) decode_addr = PIC_SEL_POST_A;
    else if (idx == PIC_IDX_POSTED_B) decode_addr = PIC_SEL_POST_B;
    else if (idx == PIC_IDX_POSTED_C) decode_addr = PIC_SEL_POST_C;
    else if (idx == PIC_IDX_ENABLE_0) decode_addr = PIC_SEL_EN_0;
    else if (idx == PIC_IDX_ENABLE_1) decode_addr = PIC_SEL_EN_1;
    else if (idx == PIC_IDX_ENABLE_2) decode_addr = PIC_SEL_EN_2;
    else if (idx == PIC_IDX_ENABLE_3) decode_addr = PIC_SEL_EN_3;
    else decode_addr = PIC_SEL_NONE;
  endfunction : decode_addr

  logic [PIC_NSRC-1:0] posted;
  logic [PIC_NSRC-1:0] enable_vec;
  logic [PIC_NSRC-1:0] pending;
  logic [PIC_NSRC-1:0] hw_post;
  logic [PIC_NSRC-1:0] sw_set;
  logic [PIC_NSRC-1:0] sw_clr;
  logic [PIC_NSRC-1:0] acc_clr;
  logic [PIC_NSRC-1:0] impl;
  logic [PIC_NPIN-1:0] pin_s1;
  logic [PIC_NPIN-1:0] pin_s2;
  logic [PIC_NPIN-1:0] pin_s3;
  logic [PIC_NPIN-1:0] pin_level;
  logic [PIC_NPIN-1:0] pin_edge;
  logic soft_post_enable;
  logic [7:0] flag_view [0:PIC_NREG-1];
  logic [PIC_NSRC-1:0] mask_bits;
  logic [PIC_AW-1:0] aw_addr;
  logic aw_held;
  logic [7:0] w_byte;
  logic w_lane;
  logic w_held;
  logic do_write;
  pic_sel_t wsel;
  pic_state_t state;
  logic [3:0] step;
  logic [PIC_PW-1:0] win_prio;
  logic win_found;
  logic accept;
  logic [PIC_PW-1:0] sel_prio;
  logic [15:0] saved_pc;
  logic [7:0] saved_flags;
  logic [7:0] next_flags;

  // Pin synchronisers, first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end
    else if (ce)
    begin
      pin_s1 <= pin_irq;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Stable pin level once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_level <= '0;
    else if (ce)
      pin_level <= (pin_s2 == pin_s3) ? pin_s3 : pin_level;
  end

  // Rising edge of the agreed level posts the source
  assign pin_edge = (pin_s2 & pin_s3) & ~pin_level;

  // Implemented sources and mask vector from the register layout
  always_comb
  begin
    impl = '0;
    enable_vec = '0;
    for (int r = 0; r < PIC_NREG; r++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (PIC_MAP[r][b] != '0)
        begin
          impl[PIC_MAP[r][b]] = 1'b1;
          enable_vec[PIC_MAP[r][b]] = mask_bits[PIC_MAP[r][b]];
        end
      end
    end
  end

  // Read view of posted flags per register, reserved bits zero
  generate
    for (genvar r = 0; r < PIC_NREG; r++)
    begin : g_view
      for (genvar b = 0; b < 8; b++)
      begin : g_bit
        assign flag_view[r][b] = (PIC_MAP[r][b] != '0) ? posted[PIC_MAP[r][b]] : 1'b0;
      end
    end
  endgenerate

  // Hardware posting from pulses and pin edges
  always_comb
  begin
    hw_post = periph_event & impl;
    for (int p = 0; p < PIC_NPIN; p++)
    begin
      if (pin_edge[p])
        hw_post[PIC_PIN_PRIO[p]] = 1'b1;
    end
  end

  // Software post or clear through the posted-flag registers
  always_comb
  begin
    int r;
    sw_set = '0;
    sw_clr = '0;
    r = -1;
    if (wsel == PIC_SEL_POST_A) r = 0;
    else if (wsel == PIC_SEL_POST_B) r = 1;
    else if (wsel == PIC_SEL_POST_C) r = 2;
    if (do_write && w_lane && r >= 0)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (PIC_MAP[r][b] != '0)
        begin
          if (soft_post_enable)
            sw_set[PIC_MAP[r][b]] = w_byte[b];
          else
            sw_clr[PIC_MAP[r][b]] = ~w_byte[b];
        end
      end
    end
  end

  // Posted flags: set beats any clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      posted <= '0;
    else if (ce)
      posted <= (posted & ~(sw_clr | acc_clr)) | hw_post | sw_set;
  end

  // Pending needs both posted and enabled
  assign pending = posted & enable_vec;

  // Priority encoder, lowest number wins
  always_comb
  begin
    win_prio = '0;
    win_found = 1'b0;
    for (int p = PIC_NSRC - 1; p >= 0; p--)
    begin
      if (pending[p])
      begin
        win_prio = PIC_PW'(p);
        win_found = 1'b1;
      end
    end
  end

  // Flag value as it stands after this cycle's core updates
  always_comb
  begin
    next_flags = cpu_flags;
    if (return_from_service)
      next_flags = restored_flags;
    else if (flag_write)
      next_flags = flag_wdata;
  end

  // Request level; enable rising or a mask write makes it active
  assign irq_request = win_found & next_flags[PIC_FLAG_IRQ_EN_BIT];
  // Taken only at an instruction boundary, return included
  assign accept = ce && state == PIC_IDLE && instr_end && irq_request;
  assign dispatch_busy = (state == PIC_DISPATCH);

  // Acceptance clears only the chosen source
  always_comb
  begin
    acc_clr = '0;
    if (accept)
      acc_clr[win_prio] = 1'b1;
  end

  // CPU flag register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cpu_flags <= PIC_BYTE_RESET;
    else if (ce)
    begin
      if (state == PIC_DISPATCH && step == PIC_STEP_CLR_FL)
        cpu_flags <= PIC_BYTE_RESET;
      else if (state == PIC_IDLE)
        cpu_flags <= next_flags;
    end
  end

  // Dispatch sequencer: automatic call of fixed length
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= PIC_IDLE;
      step <= '0;
      sel_prio <= '0;
      saved_pc <= '0;
      saved_flags <= PIC_BYTE_RESET;
    end
    else if (ce)
    begin
      case (state)
        PIC_IDLE:
        begin
          if (accept)
          begin
            state <= PIC_DISPATCH;
            step <= '0;
            sel_prio <= win_prio;
            saved_pc <= cpu_program_counter;
            saved_flags <= next_flags;
          end
        end
        PIC_DISPATCH:
        begin
          if (step == PIC_STEP_LAST)
            state <= PIC_IDLE;
          else
            step <= step + 4'h1;
        end
        default:
          state <= PIC_IDLE;
      endcase
    end
  end

  // Stack pushes and vector load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stack_push <= 1'b0;
      stack_data <= PIC_BYTE_RESET;
      pc_load <= 1'b0;
      pc_value <= '0;
    end
    else if (ce)
    begin
      stack_push <= 1'b0;
      pc_load <= 1'b0;
      if (state == PIC_DISPATCH)
      begin
        if (step == PIC_STEP_PUSH_HI)
        begin
          stack_push <= 1'b1;
          stack_data <= saved_pc[15:8];
        end
        else if (step == PIC_STEP_PUSH_LO)
        begin
          stack_push <= 1'b1;
          stack_data <= saved_pc[7:0];
        end
        else if (step == PIC_STEP_PUSH_FL)
        begin
          stack_push <= 1'b1;
          stack_data <= saved_flags;
        end
        else if (step == PIC_STEP_LAST)
        begin
          pc_load <= 1'b1;
          pc_value <= {PIC_PC_UPPER_ON_VECTOR, 8'(sel_prio) << PIC_VEC_SHIFT};
        end
      end
    end
  end

  // AXI write channel capture, either order
  assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ce & ~w_held & ~s_axi_bvalid;
  assign do_write = ce & aw_held & w_held & ~s_axi_bvalid;
  assign wsel = decode_addr(aw_addr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_byte <= PIC_BYTE_RESET;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PIC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == PIC_SEL_NONE) ? PIC_RESP_SLVERR : PIC_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Mask and soft-post enable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_bits <= '0;
      soft_post_enable <= 1'b0;
    end
    else if (ce && do_write && w_lane)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (wsel == PIC_SEL_EN_0 && PIC_MAP[0][b] != '0)
          mask_bits[PIC_MAP[0][b]] <= w_byte[b];
        else if (wsel == PIC_SEL_EN_1 && PIC_MAP[1][b] != '0)
          mask_bits[PIC_MAP[1][b]] <= w_byte[b];
        else if (wsel == PIC_SEL_EN_2 && PIC_MAP[2][b] != '0)
          mask_bits[PIC_MAP[2][b]] <= w_byte[b];
      end
      if (wsel == PIC_SEL_EN_3)
        soft_post_enable <= w_byte[PIC_SOFT_POST_BIT];
    end
  end

  // Mask register read view
  function automatic logic [7:0] mask_view(input int r, input logic [PIC_NSRC-1:0] m);
    logic [7:0] v;
    v = '0;
    for (int b = 0; b < 8; b++)
      v[b] = (PIC_MAP[r][b] != '0) ? m[PIC_MAP[r][b]] : 1'b0;
    mask_view = v;
  endfunction : mask_view

  // AXI read channel, one cycle answer
  assign s_axi_arready = ce & ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PIC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        pic_sel_t rsel;
        rsel = decode_addr(s_axi_araddr);
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= PIC_RESP_OKAY;
        s_axi_rdata <= '0;
        if (rsel == PIC_SEL_POST_A)
          s_axi_rdata[7:0] <= flag_view[0];
        else if (rsel == PIC_SEL_POST_B)
          s_axi_rdata[7:0] <= flag_view[1];
        else if (rsel == PIC_SEL_POST_C)
          s_axi_rdata[7:0] <= flag_view[2];
        else if (rsel == PIC_SEL_EN_0)
          s_axi_rdata[7:0] <= mask_view(0, mask_bits);
        else if (rsel == PIC_SEL_EN_1)
          s_axi_rdata[7:0] <= mask_view(1, mask_bits);
        else if (rsel == PIC_SEL_EN_2)
          s_axi_rdata[7:0] <= mask_view(2, mask_bits);
        else if (rsel == PIC_SEL_EN_3)
          s_axi_rdata[PIC_SOFT_POST_BIT] <= soft_post_enable;
        else
          s_axi_rresp <= PIC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : pic_controller
`default_nettype wire

// file: test/pic_chk.sv
// Purpose: Port checker for the interrupt controller
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every controller instance
`timescale 1ns/1ps
`default_nettype none
module pic_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic instr_end,
  input wire logic irq_request,
  input wire logic dispatch_busy,
  input wire logic stack_push,
  input wire logic [7:0] cpu_flags,
  input wire logic pc_load,
  input wire logic [15:0] pc_value
);
  // One domain for all checks
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Dispatch sequencing
  property p_busy_len;
    $rose(dispatch_busy) |-> dispatch_busy[*8] ##1 dispatch_busy[*5] ##1 !dispatch_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("dispatch length wrong");
  property p_accept;
    $rose(dispatch_busy) |-> $past(instr_end) && $past(irq_request);
  endproperty
  a_accept: assert property (p_accept) else $error("dispatch without boundary");
  property p_push;
    $rose(dispatch_busy) |-> ##[0:3] stack_push[*3] ##1 !stack_push;
  endproperty
  a_push: assert property (p_push) else $error("push count wrong");
  property p_push_in;
    stack_push |-> dispatch_busy;
  endproperty
  a_push_in: assert property (p_push_in) else $error("push outside dispatch");
  property p_flags;
    $rose(dispatch_busy) |-> ##5 (cpu_flags == 8'h00)[*7];
  endproperty
  a_flags: assert property (p_flags) else $error("flags not cleared");
  property p_load;
    $rose(dispatch_busy) |-> ##[12:14] pc_load;
  endproperty
  a_load: assert property (p_load) else $error("vector load late");
  property p_vec;
    pc_load |-> pc_value[15:8] == 8'h00 && pc_value[1:0] == 2'h0 && $past(dispatch_busy, 2);
  endproperty
  a_vec: assert property (p_vec) else $error("vector malformed");

  // Register bus
  property p_wblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblk: assert property (p_wblk) else $error("write taken with response open");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rdat;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdat: assert property (p_rdat) else $error("read upper bits set");
endmodule : pic_chk

bind pic_controller pic_chk u_chk
(
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .instr_end, .irq_request, .dispatch_busy,
  .stack_push, .cpu_flags, .pc_load, .pc_value
);
`default_nettype wire

// file: test/pic_cpu_model.sv
// Purpose: CPU core stand-in facing the dispatch port
// Assumes: Instructions take four cycles
// Notes: Captures stacked bytes and vector for the bench
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dispatch_busy,
  input wire logic irq_request,
  input wire logic stack_push,
  input wire logic [7:0] stack_data,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  output logic instr_end,
  output logic [15:0] pc
);
  logic [1:0] c;
  logic [1:0] np;
  logic [7:0] nd;
  logic [7:0] pu [0:2];
  logic [15:0] spc;
  logic [15:0] vec;
  // Instruction boundary, stalled during dispatch
  assign instr_end = c == 2'h3 && !dispatch_busy;
  // Cycle count and program counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c <= 2'h0;
      pc <= 16'h1234;
    end
    else if (!dispatch_busy)
    begin
      c <= c + 2'h1;
      pc <= instr_end ? pc + 16'h0111 : pc;
    end
  end
  // Saved PC, stacked bytes, vector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      np <= 2'h0;
      nd <= 8'h00;
      spc <= 16'h0000;
      vec <= 16'h0000;
    end
    else
    begin
      if (instr_end && irq_request)
      begin
        spc <= pc;
        np <= 2'h0;
      end
      else if (stack_push)
      begin
        pu[np] <= stack_data;
        np <= np + 2'h1;
      end
      if (pc_load)
      begin
        vec <= pc_value;
        nd <= nd + 8'h01;
      end
    end
  end
endmodule : pic_cpu_model
`default_nettype wire

// file: test/prioritized_interrupt_controller_tb.sv
// Purpose: Register and dispatch tests for the interrupt controller
// Assumes: Clock enable held high, full write strobes
// Notes: Byte address is four times the register index
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_tb;
  import pic_pkg::*;
  localparam logic [11:0] pa = {2'b00, PIC_IDX_POSTED_A, 2'b00};
  localparam logic [11:0] pb = {2'b00, PIC_IDX_POSTED_B, 2'b00};
  localparam logic [11:0] pc_ = {2'b00, PIC_IDX_POSTED_C, 2'b00};
  localparam logic [11:0] m0 = {2'b00, PIC_IDX_ENABLE_0, 2'b00};
  localparam logic [11:0] m1 = {2'b00, PIC_IDX_ENABLE_1, 2'b00};
  localparam logic [11:0] m3 = {2'b00, PIC_IDX_ENABLE_3, 2'b00};
  localparam logic [11:0] rg [0:2] = '{pa, pb, pc_};
  // Priority, register, bit of each source
  localparam logic [15:0] src [0:11] = '{16'h0100, 16'h0302, 16'h0403, 16'h0504, 16'h0607,
    16'h0705, 16'h0d15, 16'h0e16, 16'h1121, 16'h1222, 16'h1424, 16'h1906};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0, a;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, flag_write = 0, return_from_service = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, got;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [25:0] periph_event = '0;
  logic [4:0] pin_irq = '0;
  logic [7:0] flag_wdata = '0, restored_flags = '0, cpu_flags, stack_data;
  logic instr_end, irq_request, dispatch_busy, stack_push, pc_load;
  logic [15:0] cpu_program_counter, pc_value;
  int miscompares = 0, n_tests = 0;

  // 100 MHz clock
  initial forever #5 aclk = ~aclk;

  pic_controller DUT
  (
    .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_event, .pin_irq, .instr_end,
    .cpu_program_counter, .flag_write, .flag_wdata, .return_from_service, .restored_flags,
    .cpu_flags, .irq_request, .dispatch_busy, .stack_push, .stack_data, .pc_load, .pc_value
  );

  pic_cpu_model u_cpu
  (
    .aclk, .aresetn, .dispatch_busy, .irq_request, .stack_push, .stack_data, .pc_load,
    .pc_value, .instr_end, .pc(cpu_program_counter)
  );

  task results;
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Wait limit used up
  task tmo(input logic ok);
    if (!ok)
    begin
      miscompares++;
      results;
    end
  endtask : tmo

  // Bus write, both channels offered together
  task wr(input logic [11:0] ad, input logic [7:0] d);
    int i;
    logic ta, tw, tb;
    tb = 0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 50 && !tb; i++)
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) s_axi_bready <= 0;
    end
    tmo(tb);
  endtask : wr

  // Bus read into got and resp
  task rd(input logic [11:0] ad);
    int i;
    logic ta, tr;
    tr = 0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 50 && !tr; i++)
    begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      got = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
      if (tr) s_axi_rready <= 0;
    end
    tmo(tr);
  endtask : rd

  task rc(input logic [11:0] ad, input logic [7:0] e);
    rd(ad);
    chk(got, {24'h0, e});
  endtask : rc

  // Flag write or return pulse from the core
  task cpu(input logic r, input logic [7:0] v);
    @(posedge aclk);
    flag_write <= !r;
    return_from_service <= r;
    flag_wdata <= v;
    restored_flags <= v;
    @(posedge aclk);
    flag_write <= 0;
    return_from_service <= 0;
  endtask : cpu

  // Wait for dispatch number n and check what it left
  task disp(input logic [7:0] n, input logic [7:0] v, input logic [7:0] f);
    int i;
    for (i = 0; i < 200 && u_cpu.nd !== n; i++) @(negedge aclk);
    tmo(i < 200);
    chk(u_cpu.vec, {8'h00, v});
    chk(u_cpu.pu[0], u_cpu.spc[15:8]);
    chk(u_cpu.pu[1], u_cpu.spc[7:0]);
    chk(u_cpu.pu[2], f);
    chk(cpu_flags, 8'h00);
    @(posedge aclk);
  endtask : disp

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rc(pa, 8'h00);
    rc(pb, 8'h00);
    rc(pc_, 8'h00);
    rd(12'h004);
    chk(resp, PIC_RESP_SLVERR);
    wr(12'h004, 8'hff);
    chk(resp, PIC_RESP_SLVERR);
    // Software posting on, then off
    wr(m3, 8'h80);
    wr(pa, 8'hff);
    rc(pa, 8'hfd);
    wr(pb, 8'hff);
    rc(pb, 8'h60);
    wr(pc_, 8'hff);
    rc(pc_, 8'h16);
    wr(pa, 8'h00);
    rc(pa, 8'hfd);
    wr(m3, 8'h00);
    wr(pa, 8'hff);
    rc(pa, 8'hfd);
    wr(pa, 8'hfe);
    rc(pa, 8'hfc);
    wr(pa, 8'h00);
    wr(pb, 8'h00);
    wr(pc_, 8'h00);
    // Each hardware source posts its own bit
    foreach (src[k])
    begin
      a = rg[src[k][7:4]];
      @(posedge aclk);
      periph_event[src[k][12:8]] <= 1'b1;
      @(posedge aclk);
      periph_event <= '0;
      rc(a, 8'h01 << src[k][3:0]);
      wr(a, ~(8'h01 << src[k][3:0]));
      rc(a, 8'h00);
    end
    // Pin edge posts once, held level does not
    @(posedge aclk);
    pin_irq[1] <= 1'b1;
    repeat (8) @(posedge aclk);
    rc(pa, 8'h80);
    wr(pa, 8'h7f);
    repeat (8) @(posedge aclk);
    rc(pa, 8'h00);
    // Masked posting, then unmask activates
    cpu(0, 8'h01);
    @(posedge aclk);
    periph_event <= 26'h0006000;
    @(posedge aclk);
    periph_event <= '0;
    repeat (20) @(posedge aclk);
    chk(u_cpu.nd, 8'h00);
    rc(pb, 8'h60);
    wr(m1, 8'h20);
    disp(8'h01, 8'h34, 8'h01);
    rc(pb, 8'h40);
    // Global enable off blocks, rising enable dispatches by priority
    @(posedge aclk);
    periph_event[25] <= 1'b1;
    @(posedge aclk);
    periph_event <= '0;
    wr(m0, 8'h40);
    wr(m1, 8'h60);
    rc(m0, 8'h40);
    rc(m1, 8'h60);
    repeat (20) @(posedge aclk);
    chk(u_cpu.nd, 8'h01);
    cpu(0, 8'h01);
    disp(8'h02, 8'h38, 8'h01);
    cpu(1, 8'h01);
    disp(8'h03, 8'h64, 8'h01);
    rc(pa, 8'h00);
    results;
  end
endmodule : prioritized_interrupt_controller_tb
`default_nettype wire
